/* File: rtl/boot_select_pkg.sv */
package boot_select_pkg;

   // ----------------------------------------------------------------------
   // Register map, one aligned word each.
   // ----------------------------------------------------------------------
   localparam logic [7:0]  OFS_STATUS      = 8'h00;
   localparam logic [7:0]  OFS_CONTROL     = 8'h04;
   localparam logic [7:0]  OFS_CONFIG      = 8'h08;
   localparam logic [7:0]  OFS_ACCESS      = 8'h0c;

   // ----------------------------------------------------------------------
   // Boot values.
   // ----------------------------------------------------------------------
   localparam logic [7:0]  FLASH_CTRL_HW_BOOT = 8'h00;
   localparam logic [7:0]  FLASH_CTRL_NORMAL  = 8'hf0;
   localparam logic [15:0] START_USER      = 16'h0000;
   localparam logic [15:0] START_BOOTLOAD  = 16'hf800;
   localparam logic [7:0]  BOOT_VECTOR_NONE      = 8'hfc;
   localparam logic        JUMP_SELECT_DELIVERED = 1'b0;
   localparam logic [1:0]  SYNC_SETTLE     = 2'h2;

   // ----------------------------------------------------------------------
   // Field positions in the status word.
   // ----------------------------------------------------------------------
   localparam int          ST_ROM_EN_BIT   = 0;
   localparam int          ST_HWBOOT_BIT   = 1;
   localparam int          ST_DONE_BIT     = 2;
   localparam int          ST_JUMP_SEL_BIT   = 3;
   localparam int          ST_FLASH_CTRL_LSB = 8;
   localparam int          ST_START_LSB    = 16;

   // ----------------------------------------------------------------------
   // Code locations and target spaces of the access checker.
   // ----------------------------------------------------------------------
   localparam logic [1:0]  LOC_BOOT_FLASH  = 2'h0;
   localparam logic [1:0]  LOC_USER_FLASH  = 2'h1;
   localparam logic [1:0]  LOC_EXTERNAL    = 2'h2;

   localparam logic [2:0]  SP_BOOT_FLASH   = 3'h0;
   localparam logic [2:0]  SP_USER_FLASH   = 3'h1;
   localparam logic [2:0]  SP_EEPROM       = 3'h2;
   localparam logic [2:0]  SP_HW_BYTE      = 3'h3;
   localparam logic [2:0]  SP_EXTRA_ROW    = 3'h4;

   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

   typedef enum logic [1:0] {ST_WAIT, ST_SETTLE, ST_RUN} boot_state_type;

endpackage

/* File: rtl/boot_select_memory_access.sv */
`timescale 1ns/1ps
module boot_select_memory_access
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   input  wire logic        i_prog_strobe_pin,
   input  wire logic        i_ext_access_pin,
   input  wire logic        i_addr_latch_pin,
   input  wire logic        i_boot_jump_select_bit,
   input  wire logic [7:0]  i_user_boot_vector_byte,
   input  wire logic [7:0]  i_extra_config_byte,
   input  wire logic [7:0]  i_boot_status_byte,
   input  wire logic        i_acc_req,
   input  wire logic        i_acc_write,
   input  wire logic [2:0]  i_acc_space,
   input  wire logic [1:0]  i_code_loc,
   input  wire logic        i_core_idle,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic [31:0]      o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic             o_boot_rom_enable,
   output logic [7:0]       o_flash_control_reg,
   output logic [15:0]      o_start_addr,
   output logic             o_boot_done,
   output logic [15:0]      o_user_boot_start,
   output logic             o_user_boot_present,
   output logic             o_prog_strobe_out,
   output logic             o_prog_strobe_oe,
   output logic             o_acc_grant,
   output logic             o_acc_deny,
   output logic             o_acc_overlap_wr
);

   // ----------------------------------------------------------------------
   // Strap synchronisers.
   // ----------------------------------------------------------------------
   logic [2:0]                          strap_meta_ff;
   logic [2:0]                          strap_sync_ff;
   logic                                jump_sel_ff;
   boot_select_pkg::boot_state_type     state_ff;
   logic [1:0]                          settle_ff;
   logic                                hw_boot_ff;
   logic                                hw_boot_now;
   logic [7:0]                          deny_count_ff;
   logic [2:0]                          last_deny_ff;
   logic                                wr_pend_ff;
   logic [7:0]                          wr_addr_ff;
   logic                                permit;
   logic                                marked_overlap;
   logic [31:0]                         nxt_rdata;

   // Only the second stage is ever read; stage one feeds nothing else.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         strap_meta_ff <= 3'h7;
         strap_sync_ff <= 3'h7;
      end
      else
      begin
         strap_meta_ff <= {i_addr_latch_pin, i_ext_access_pin, i_prog_strobe_pin};
         strap_sync_ff <= strap_meta_ff;
      end
   end

   // Strobe low, external access high, latch strobe high or pulled up.
   assign hw_boot_now = ~strap_sync_ff[0] & strap_sync_ff[1] & strap_sync_ff[2];

   // ----------------------------------------------------------------------
   // Boot selection sequencer.
   // ----------------------------------------------------------------------
   // The select bit shadow resets to the delivered value, then follows the store until ST_RUN.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         jump_sel_ff <= boot_select_pkg::JUMP_SELECT_DELIVERED;
      else if (state_ff != boot_select_pkg::ST_RUN)
         jump_sel_ff <= i_boot_jump_select_bit;
   end

   // Waits for the pins to cross the synchroniser, then decides once.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_ff  <= boot_select_pkg::ST_WAIT;
         settle_ff <= 2'h0;
      end
      else
      begin
         case (state_ff)
            boot_select_pkg::ST_WAIT:
            begin
               state_ff  <= boot_select_pkg::ST_SETTLE;
               settle_ff <= 2'h1;
            end
            boot_select_pkg::ST_SETTLE:
            begin
               if (settle_ff == boot_select_pkg::SYNC_SETTLE)
                  state_ff <= boot_select_pkg::ST_RUN;
               else
                  settle_ff <= settle_ff + 2'h1;
            end
            boot_select_pkg::ST_RUN:
               state_ff <= boot_select_pkg::ST_RUN;
            default:
               state_ff <= boot_select_pkg::ST_WAIT;
         endcase
      end
   end

   // The outcome is written in the single decision cycle; only flash control and the ROM enable change again, by software.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         hw_boot_ff          <= 1'b0;
         o_flash_control_reg <= boot_select_pkg::FLASH_CTRL_NORMAL;
         o_start_addr        <= boot_select_pkg::START_BOOTLOAD;
         o_boot_rom_enable   <= 1'b0;
         o_boot_done         <= 1'b0;
         o_prog_strobe_oe    <= 1'b0;
      end
      else if (state_ff == boot_select_pkg::ST_SETTLE
               && settle_ff == boot_select_pkg::SYNC_SETTLE)
      begin
         hw_boot_ff        <= hw_boot_now;
         o_boot_rom_enable <= jump_sel_ff;
         o_boot_done       <= 1'b1;
         o_prog_strobe_oe  <= 1'b1;
         if (hw_boot_now)
         begin
            o_flash_control_reg <= boot_select_pkg::FLASH_CTRL_HW_BOOT;
            o_start_addr        <= boot_select_pkg::START_BOOTLOAD;
         end
         else
         begin
            o_flash_control_reg <= boot_select_pkg::FLASH_CTRL_NORMAL;
            o_start_addr        <= jump_sel_ff ? boot_select_pkg::START_USER
                                           : boot_select_pkg::START_BOOTLOAD;
         end
      end
      else if (wr_pend_ff && o_boot_done)
      begin
         // Software may later rewrite flash control and the boot ROM enable.
         if (wr_addr_ff == boot_select_pkg::OFS_CONTROL)
         begin
            o_flash_control_reg <= i_hwdata[7:0];
            o_boot_rom_enable   <= i_hwdata[boot_select_pkg::ST_ROM_EN_BIT + 8];
         end
      end
   end

   // Strobe pin idles high while driven; the board has let go by now.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         o_prog_strobe_out <= 1'b1;
      else
         o_prog_strobe_out <= 1'b1;
   end

   // User bootloader start from the vector byte.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_user_boot_start   <= {boot_select_pkg::BOOT_VECTOR_NONE, 8'h00};
         o_user_boot_present <= 1'b0;
      end
      else
      begin
         o_user_boot_start   <= {i_user_boot_vector_byte, 8'h00};
         o_user_boot_present <= (i_user_boot_vector_byte != boot_select_pkg::BOOT_VECTOR_NONE);
      end
   end

   // ----------------------------------------------------------------------
   // Cross memory access checker.
   // ----------------------------------------------------------------------
   always_comb
   begin
      permit     = 1'b0;
      marked_overlap = 1'b0;
      case (i_code_loc)
         boot_select_pkg::LOC_BOOT_FLASH:
         begin
            if (!i_acc_write)
               permit = (i_acc_space != boot_select_pkg::SP_EXTRA_ROW);
            else
               permit = (i_acc_space != boot_select_pkg::SP_BOOT_FLASH);
            marked_overlap = i_acc_write;
         end
         boot_select_pkg::LOC_USER_FLASH:
         begin
            if (!i_acc_write)
               permit = (i_acc_space != boot_select_pkg::SP_EXTRA_ROW);
            else if (i_acc_space == boot_select_pkg::SP_USER_FLASH)
               permit = i_core_idle;
            else
               permit = (i_acc_space == boot_select_pkg::SP_EEPROM)
                        || (i_acc_space == boot_select_pkg::SP_EXTRA_ROW);
            marked_overlap = i_acc_write && (i_acc_space == boot_select_pkg::SP_EEPROM);
         end
         boot_select_pkg::LOC_EXTERNAL:
         begin
            permit         = (i_acc_space == boot_select_pkg::SP_EEPROM);
            marked_overlap = i_acc_write;
         end
         default:
         begin
            permit         = 1'b0;
            marked_overlap = 1'b0;
         end
      endcase
   end

   // A refused access only raises deny; the core is never held.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_acc_grant <= 1'b0;
         o_acc_deny  <= 1'b0;
         o_acc_overlap_wr <= 1'b0;
      end
      else
      begin
         o_acc_grant <= i_acc_req & permit;
         o_acc_deny  <= i_acc_req & ~permit;
         o_acc_overlap_wr <= i_acc_req & permit & marked_overlap;
      end
   end

   // Saturating count of refusals and the last refused space.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         deny_count_ff <= 8'h00;
         last_deny_ff  <= 3'h0;
      end
      else if (i_acc_req && !permit)
      begin
         if (deny_count_ff != 8'hff)
            deny_count_ff <= deny_count_ff + 8'h01;
         last_deny_ff <= i_acc_space;
      end
   end

   // ----------------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY.
   // ----------------------------------------------------------------------
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      case (i_haddr[7:0])
         boot_select_pkg::OFS_STATUS:
         begin
            nxt_rdata[boot_select_pkg::ST_ROM_EN_BIT]          = o_boot_rom_enable;
            nxt_rdata[boot_select_pkg::ST_HWBOOT_BIT]          = hw_boot_ff;
            nxt_rdata[boot_select_pkg::ST_DONE_BIT]            = o_boot_done;
            nxt_rdata[boot_select_pkg::ST_JUMP_SEL_BIT]        = jump_sel_ff;
            nxt_rdata[boot_select_pkg::ST_FLASH_CTRL_LSB +: 8] = o_flash_control_reg;
            nxt_rdata[boot_select_pkg::ST_START_LSB +: 16]  = o_start_addr;
         end
         boot_select_pkg::OFS_CONTROL:
         begin
            nxt_rdata[7:0]                                  = o_flash_control_reg;
            nxt_rdata[boot_select_pkg::ST_ROM_EN_BIT + 8]   = o_boot_rom_enable;
         end
         boot_select_pkg::OFS_CONFIG:
            nxt_rdata = {8'h00, i_boot_status_byte, i_extra_config_byte,
                         i_user_boot_vector_byte};
         boot_select_pkg::OFS_ACCESS:
            nxt_rdata = {21'h000000, last_deny_ff, deny_count_ff};
         default:
            nxt_rdata = 32'h0000_0000;
      endcase
   end

   // Read data is fetched in the address phase and stands in the data phase.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_hrdata    <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         wr_pend_ff  <= 1'b0;
         wr_addr_ff  <= 8'h00;
      end
      else if (i_hready)
      begin
         wr_pend_ff <= i_hsel && (i_htrans == boot_select_pkg::HTRANS_NONSEQ) && i_hwrite;
         wr_addr_ff <= i_haddr[7:0];
         if (i_hsel && (i_htrans == boot_select_pkg::HTRANS_NONSEQ) && !i_hwrite)
            o_hrdata <= nxt_rdata;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------------
   sequence s_decide;
      state_ff == boot_select_pkg::ST_SETTLE && settle_ff == boot_select_pkg::SYNC_SETTLE;
   endsequence

   property p_rom_en_load;
      @(posedge i_mclk) disable iff (i_reset)
      s_decide |=> (o_boot_rom_enable == $past(jump_sel_ff) && o_boot_done);
   endproperty
   a_rom_en_load: assert property (p_rom_en_load) else $error("boot enable not loaded");

   property p_hw_flash_ctrl;
      @(posedge i_mclk) disable iff (i_reset)
      (s_decide and hw_boot_now) |=> (o_flash_control_reg == boot_select_pkg::FLASH_CTRL_HW_BOOT
                                      && o_start_addr == boot_select_pkg::START_BOOTLOAD);
   endproperty
   a_hw_flash_ctrl: assert property (p_hw_flash_ctrl) else $error("hardware boot preset wrong");

   property p_norm_flash_ctrl;
      @(posedge i_mclk) disable iff (i_reset)
      (s_decide and !hw_boot_now) |=> o_flash_control_reg == boot_select_pkg::FLASH_CTRL_NORMAL;
   endproperty
   a_norm_flash_ctrl: assert property (p_norm_flash_ctrl) else $error("normal flash preset wrong");

   property p_user_start;
      @(posedge i_mclk) disable iff (i_reset)
      (s_decide and !hw_boot_now and jump_sel_ff) |=> o_start_addr == boot_select_pkg::START_USER;
   endproperty
   a_user_start: assert property (p_user_start) else $error("user start wrong");

   property p_boot_start;
      @(posedge i_mclk) disable iff (i_reset)
      (s_decide and !jump_sel_ff) |=> o_start_addr == boot_select_pkg::START_BOOTLOAD;
   endproperty
   a_boot_start: assert property (p_boot_start) else $error("bootloader start wrong");

   property p_once;
      @(posedge i_mclk) disable iff (i_reset)
      o_boot_done |=> ($stable(o_start_addr) && $stable(hw_boot_ff) && o_boot_done);
   endproperty
   a_once: assert property (p_once) else $error("boot selection changed");

   property p_no_boot_write;
      @(posedge i_mclk) disable iff (i_reset)
      (i_acc_req && i_acc_write && i_acc_space == boot_select_pkg::SP_BOOT_FLASH)
         |=> (o_acc_deny && !o_acc_grant);
   endproperty
   a_no_boot_write: assert property (p_no_boot_write) else $error("boot flash written");

   property p_user_idle;
      @(posedge i_mclk) disable iff (i_reset)
      (i_acc_req && i_acc_write && i_code_loc == boot_select_pkg::LOC_USER_FLASH
       && i_acc_space == boot_select_pkg::SP_USER_FLASH) |=> o_acc_grant == $past(i_core_idle);
   endproperty
   a_user_idle: assert property (p_user_idle) else $error("idle write rule broken");

   property p_ext_only_eeprom;
      @(posedge i_mclk) disable iff (i_reset)
      (i_acc_req && i_code_loc == boot_select_pkg::LOC_EXTERNAL
       && i_acc_space != boot_select_pkg::SP_EEPROM) |=> o_acc_deny;
   endproperty
   a_ext_only_eeprom: assert property (p_ext_only_eeprom) else $error("external reach");

   property p_deny_excl;
      @(posedge i_mclk) disable iff (i_reset)
      o_acc_deny |-> (!o_acc_grant && !o_acc_overlap_wr);
   endproperty
   a_deny_excl: assert property (p_deny_excl) else $error("denied access granted");

endmodule

/* File: test/strap_model.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Board-side strap drivers for the three boot pins.
// --------------------------------------------------------------------------
module strap_model
(
   input  wire logic i_mclk,
   input  wire logic i_reset,
   input  wire logic i_strobe_lvl,
   input  wire logic i_ext_lvl,
   input  wire logic i_latch_lvl,
   input  wire logic i_strobe_out,
   input  wire logic i_strobe_oe,
   output logic      o_strobe_pin,
   output logic      o_ext_pin,
   output logic      o_latch_pin
);
   logic [1:0] hold_ff;
   logic       powered_ff = 1'b0;
   logic       drive;
   // Straps are held through reset and the synchroniser delay after it, then dropped.
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         hold_ff <= 2'h0;
      else if (hold_ff != 2'h3)
         hold_ff <= hold_ff + 2'h1;
   end
   // The first power-on reset never pulls the strobe low.
   always @(negedge i_reset)
      powered_ff = 1'b1;
   assign drive = i_reset || hold_ff != 2'h3;
   // Released pins show the inverse level so a stale value cannot pass for a sample.
   assign o_strobe_pin = i_strobe_oe ? i_strobe_out :
                         drive ? (i_strobe_lvl | ~powered_ff) : ~i_strobe_lvl;
   assign o_ext_pin    = drive ? i_ext_lvl : ~i_ext_lvl;
   assign o_latch_pin  = drive ? i_latch_lvl : ~i_latch_lvl;
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic        i_mclk = 1'b0;
   logic        i_reset = 1'b1;
   logic        s_lvl = 1'b1, e_lvl = 1'b1, l_lvl = 1'b1, bjsb = 1'b0;
   logic [7:0]  vec = 8'hfc, xb = 8'h00, sb = 8'h00;
   logic        acc_req = 1'b0, acc_write = 1'b0, core_idle = 1'b0;
   logic [2:0]  acc_space = 3'h0;
   logic [1:0]  code_loc = 2'h0, htrans = 2'h0;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, wv;
   wire         strobe_pin, ext_pin, latch_pin, hreadyout, hresp, rom_en, done, present;
   wire         strobe_out, strobe_oe, grant, deny, overlap;
   wire  [31:0] hrdata;
   wire  [7:0]  flash_ctrl;
   wire  [15:0] start, ub_start;
   logic [2:0]  exp_q[$];
   logic [2:0]  last_sp = 3'h0;
   logic [7:0]  deny_cnt = 8'h00;
   int          failures = 0, total_checks = 0, seed;

   // -----------------------------------------------------------------------
   // Clock, design and board model.
   // -----------------------------------------------------------------------
   always #10 i_mclk = ~i_mclk;

   boot_select_memory_access boot_select_memory_access_i (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_prog_strobe_pin(strobe_pin),
      .i_ext_access_pin(ext_pin), .i_addr_latch_pin(latch_pin),
      .i_boot_jump_select_bit(bjsb), .i_user_boot_vector_byte(vec),
      .i_extra_config_byte(xb), .i_boot_status_byte(sb), .i_acc_req(acc_req),
      .i_acc_write(acc_write), .i_acc_space(acc_space), .i_code_loc(code_loc),
      .i_core_idle(core_idle), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
      .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
      .o_boot_rom_enable(rom_en), .o_flash_control_reg(flash_ctrl), .o_start_addr(start),
      .o_boot_done(done), .o_user_boot_start(ub_start), .o_user_boot_present(present),
      .o_prog_strobe_out(strobe_out), .o_prog_strobe_oe(strobe_oe), .o_acc_grant(grant),
      .o_acc_deny(deny), .o_acc_overlap_wr(overlap));

   strap_model strap_model_i (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_strobe_lvl(s_lvl), .i_ext_lvl(e_lvl),
      .i_latch_lvl(l_lvl), .i_strobe_out(strobe_out), .i_strobe_oe(strobe_oe),
      .o_strobe_pin(strobe_pin), .o_ext_pin(ext_pin), .o_latch_pin(latch_pin));

   // -----------------------------------------------------------------------
   // Comparison, verdict and bus tasks.
   // -----------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic fail_out();
      failures++;
      test_done();
   endtask

   // One single AHB transfer; entered and left just after a rising edge.
   task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= boot_select_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, ad};
      hwrite <= wr;
      do @(posedge i_mclk); while (hreadyout !== 1'b1 && ++n < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge i_mclk); while (hreadyout !== 1'b1 && ++n < 20);
      rd = hrdata;
      check(hresp, 1'b0);
      if (n >= 20)
         fail_out();
   endtask

   // Boot outputs expected from the strap code {strobe, ext, latch, select}.
   task automatic boot_check(input logic [3:0] k);
      logic        hw;
      logic [7:0]  f_exp;
      logic [15:0] s_exp;
      hw    = !k[3] && k[2] && k[1];
      f_exp = hw ? boot_select_pkg::FLASH_CTRL_HW_BOOT : boot_select_pkg::FLASH_CTRL_NORMAL;
      s_exp = (hw || !k[0]) ? boot_select_pkg::START_BOOTLOAD : boot_select_pkg::START_USER;
      check(flash_ctrl, f_exp);
      check(start, s_exp);
      check(rom_en, k[0]);
      check({strobe_oe, strobe_out}, 2'h3);
      check({present, ub_start}, {vec != 8'hfc, vec, 8'h00});
      ahb(1'b0, boot_select_pkg::OFS_STATUS, 32'h0);
      check(rd & 32'hffff_ff0f, {s_exp, f_exp, 4'h0, k[0], 1'b1, hw, k[0]});
   endtask

   // Access answers from the permission table as {grant, deny, rww}.
   function automatic logic [2:0] acc_exp(logic [1:0] lc, logic w, logic [2:0] sp, logic idl);
      logic r, wr, ok;
      r  = (lc < 2'h2 && sp < 3'h4) || (lc == 2'h2 && sp == 3'h2);
      wr = (lc == 2'h0 && sp != 3'h0) || (lc == 2'h2 && sp == 3'h2) ||
           (lc == 2'h1 && (sp == 3'h2 || sp == 3'h4 || (sp == 3'h1 && idl)));
      ok = w ? wr : r;
      return {ok, ~ok, w && ok && (lc == 2'h0 || sp == 3'h2)};
   endfunction

   // -----------------------------------------------------------------------
   // Monitor: each answer pulse takes the oldest expectation.
   // -----------------------------------------------------------------------
   always @(posedge i_mclk)
      if (grant === 1'b1 || deny === 1'b1)
         check({grant, deny, overlap}, exp_q.size() ? exp_q.pop_front() : 3'h7);

   // -----------------------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------------------
   initial
   begin
      seed = $urandom(39);
      repeat (16) @(posedge i_mclk);
      i_reset <= 1'b0;
      // Every strap and select combination, each after a fresh reset.
      for (int k = 0; k < 16; k++)
      begin
         int n;
         @(posedge i_mclk);
         i_reset <= 1'b1;
         {s_lvl, e_lvl, l_lvl, bjsb} <= 4'(k);
         vec <= k[1] ? 8'hfc : 8'($urandom);
         xb <= 8'($urandom);
         sb <= 8'($urandom);
         repeat (3) @(posedge i_mclk);
         i_reset <= 1'b0;
         n = 0;
         do @(posedge i_mclk); while (done !== 1'b1 && ++n < 20);
         if (n >= 20)
            fail_out();
         boot_check(4'(k));
         ahb(1'b0, boot_select_pkg::OFS_CONFIG, 32'h0);
         check(rd & 32'h00ff_ffff, {8'h00, sb, xb, vec});
         bjsb <= ~bjsb; // Selection must not follow later pin or bit changes.
         repeat (4) @(posedge i_mclk);
         boot_check(4'(k));
      end
      // Whole permission matrix, one request every cycle.
      for (int m = 0; m < 80; m++)
      begin
         logic [2:0] e;
         e = acc_exp(2'(m / 20), m[0], 3'((m / 2) % 5), m[1]);
         @(posedge i_mclk);
         acc_req <= 1'b1;
         code_loc <= 2'(m / 20);
         acc_space <= 3'((m / 2) % 5);
         acc_write <= m[0];
         core_idle <= m[1];
         exp_q.push_back(e);
         if (e[1])
         begin
            deny_cnt = deny_cnt + 8'h01;
            last_sp = 3'((m / 2) % 5);
         end
      end
      @(posedge i_mclk);
      acc_req <= 1'b0;
      repeat (3) @(posedge i_mclk);
      check(exp_q.size(), 0);
      ahb(1'b0, boot_select_pkg::OFS_ACCESS, 32'h0);
      check(rd & 32'h7ff, {21'h0, last_sp, deny_cnt});
      // A control write, a read-only write and an unmapped place.
      wv = $urandom;
      ahb(1'b1, boot_select_pkg::OFS_CONTROL, wv);
      ahb(1'b1, boot_select_pkg::OFS_STATUS, 32'hffff_ffff);
      ahb(1'b1, 8'h10, 32'hffff_ffff);
      ahb(1'b0, boot_select_pkg::OFS_CONTROL, 32'h0);
      check(rd & 32'h1ff, wv & 32'h1ff);
      check({rom_en, flash_ctrl}, wv[8:0]);
      ahb(1'b0, boot_select_pkg::OFS_STATUS, 32'h0);
      check(rd[15:8], wv[7:0]);
      ahb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      test_done();
   end

   // Run limit in case a handshake never arrives.
   initial
   begin
      #1000000;
      fail_out();
   end
endmodule
